// file: inc/sgs_pkg.sv
// Constants and types shared by the sine gain and switch register block
`default_nettype none

package sgs_pkg;

    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SINE_GAIN_OFS = 8'h01;
    localparam logic [7:0] ROUTE_RATE_OFS = 8'h02;
    localparam logic [7:0] STATUS_OFS = 8'h10;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SINE_GAIN_RST = 8'h00;
    localparam logic [7:0] ROUTE_RATE_RST = 8'h00;
    localparam logic [7:0] RD_IDLE = 8'h00;

    // ------------------------------------------------------------
    // Field positions of the routing and rate register
    // ------------------------------------------------------------
    localparam int BAND_BIT = 7;
    localparam int ROUTE_HI = 6;
    localparam int ROUTE_LO = 4;
    localparam int COARSE_HI = 3;
    localparam int COARSE_LO = 0;

    // ------------------------------------------------------------
    // Gain encoding
    // ------------------------------------------------------------
    localparam logic [7:0] MUTE_FIRST = 8'hf0;
    localparam logic [9:0] RANGE_STEP_HALF_DB = 10'h00c;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_DIGITAL = 2'h2;

    // ------------------------------------------------------------
    // Switch routing codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SGS_ROUTE_OPEN = 3'h0,
        SGS_ROUTE_DIFF = 3'h1,
        SGS_ROUTE_DIFF_REV = 3'h2,
        SGS_ROUTE_CM_POS = 3'h3,
        SGS_ROUTE_CM_NEG = 3'h4,
        SGS_ROUTE_SE_POS = 3'h5,
        SGS_ROUTE_SE_NEG = 3'h6,
        SGS_ROUTE_SHORT = 3'h7
    } sgs_route_type;

endpackage

`default_nettype wire

// file: logic/sgs_regs.sv
// Sine gain, frequency range and signal switch configuration registers
`default_nettype none

// Behaviour
// - Sine digital gain is minus half the gain code in dB; reset gives 0 dB.
// - Gain codes f0 through ff mute the sine output completely.
// - Gain code reads as decibels: negate the value, then halve it.
// - Bit 7 of routing register picks the sine frequency range.
// - Routing field bits 6..4 set the switches while the gate pin is high.
// - Gate pin low forces every switch open, except in digital data mode.
// - In digital data mode switches follow the routing field alone.
// - Code 000 open (reset), 001 straight, 010 crossed.
// - 011 both from positive, 100 both from negative, 101/110 single, 111 short.
// - Bits 3..0 hold the coarse frequency factor for the synthesiser.
// - Mode value 10 is digital data mode.
// - Sine amplitude combines analog range and digital attenuation.
module sgs_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // Device context
    input wire logic [1:0] op_mode,
    input wire logic [2:0] analog_range,
    input wire logic route_gate_pin,
    // Sine generator controls
    output logic [7:0] digital_atten_value,
    output logic sine_mute,
    output logic [9:0] sine_total_atten,
    output logic sine_band_select,
    output logic [3:0] coarse_factor,
    // Signal switch
    output logic route_in_pos_to_out_pos,
    output logic route_in_neg_to_out_neg,
    output logic route_in_pos_to_out_neg,
    output logic route_in_neg_to_out_pos,
    output logic route_out_short
);

    // ------------------------------------------------------------
    // Registers and pin synchroniser
    // ------------------------------------------------------------
    logic [7:0] sine_gain_reg;
    logic [7:0] route_rate_reg;
    logic gate_meta;
    logic gate_sync;
    logic [2:0] route_active;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic sel_gain;
    wire logic sel_route;
    wire logic sel_status;
    wire logic wr_gain;
    wire logic wr_route;
    wire logic digital_mode;
    wire logic [2:0] route_config;
    wire logic [7:0] sine_atten_code;
    wire logic next_mute;
    wire logic [9:0] next_total;
    wire logic [7:0] status_word;
    wire logic [7:0] next_rd_data;

    assign sel_gain = (addr == sgs_pkg::SINE_GAIN_OFS);
    assign sel_route = (addr == sgs_pkg::ROUTE_RATE_OFS);
    assign sel_status = (addr == sgs_pkg::STATUS_OFS);
    assign wr_gain = wr_en & sel_gain;
    assign wr_route = wr_en & sel_route;

    assign digital_mode = (op_mode == sgs_pkg::MODE_DIGITAL);
    assign route_config = route_rate_reg[sgs_pkg::ROUTE_HI:sgs_pkg::ROUTE_LO];
    assign sine_atten_code = sine_gain_reg;

    // Codes at or above the mute threshold mute the sine output
    assign next_mute = (sine_atten_code >= sgs_pkg::MUTE_FIRST);

    // Attenuation in half-dB units; a range step is 6 dB
    assign next_total = ({7'h00, analog_range} * sgs_pkg::RANGE_STEP_HALF_DB)
                        + {2'h0, sine_atten_code};

    assign status_word = {gate_sync, sine_mute, digital_mode, 2'h0, route_active};

    // Unmapped offsets read as zero
    assign next_rd_data = !rd_en ? sgs_pkg::RD_IDLE :
                          sel_gain ? sine_gain_reg :
                          sel_route ? route_rate_reg :
                          sel_status ? status_word :
                          sgs_pkg::RD_IDLE;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sine_gain_reg <= sgs_pkg::SINE_GAIN_RST;
        end else if (wr_gain) begin
            sine_gain_reg <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            route_rate_reg <= sgs_pkg::ROUTE_RATE_RST;
        end else if (wr_route) begin
            route_rate_reg <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // Gate pin synchroniser
    // ------------------------------------------------------------
    // Pin is asynchronous; only the second stage feeds logic
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            gate_meta <= 1'h0;
            gate_sync <= 1'h0;
        end else begin
            gate_meta <= route_gate_pin;
            gate_sync <= gate_meta;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rd_data <= sgs_pkg::RD_IDLE;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // ------------------------------------------------------------
    // Sine generator outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            digital_atten_value <= sgs_pkg::SINE_GAIN_RST;
            sine_mute <= 1'h0;
            sine_total_atten <= 10'h000;
        end else begin
            digital_atten_value <= sine_atten_code;
            sine_mute <= next_mute;
            sine_total_atten <= next_total;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sine_band_select <= 1'h0;
            coarse_factor <= 4'h0;
        end else begin
            sine_band_select <= route_rate_reg[sgs_pkg::BAND_BIT];
            coarse_factor <= route_rate_reg[sgs_pkg::COARSE_HI:sgs_pkg::COARSE_LO];
        end
    end

    // ------------------------------------------------------------
    // Signal switch
    // ------------------------------------------------------------
    // Gate lags the pin by the synchroniser, two cycles plus the output flop
    sgs_route_switch sgs_route_switch_i (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .route_config(route_config),
        .gate_sync(gate_sync),
        .digital_mode(digital_mode),
        .pos_to_pos(route_in_pos_to_out_pos),
        .neg_to_neg(route_in_neg_to_out_neg),
        .pos_to_neg(route_in_pos_to_out_neg),
        .neg_to_pos(route_in_neg_to_out_pos),
        .out_short(route_out_short),
        .route_active(route_active)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_gain_write_audible;
        wr_en && sel_gain && (wr_data < sgs_pkg::MUTE_FIRST);
    endsequence

    sequence s_gain_write_mute;
        wr_en && sel_gain && (wr_data >= sgs_pkg::MUTE_FIRST);
    endsequence

    sequence s_route_write;
        wr_en && sel_route;
    endsequence

    property p_gain_apply;
        logic [7:0] v;
        (s_gain_write_audible, v = wr_data) ##2 !$past(wr_gain) |->
            (digital_atten_value == v) && !sine_mute;
    endproperty
    a_gain_apply: assert property (p_gain_apply) else $error("gain code not applied");

    property p_gain_reset;
        $past(nrst) == 1'h0 |-> (sine_gain_reg == 8'h00) && (route_rate_reg == 8'h00);
    endproperty
    a_gain_reset: assert property (p_gain_reset) else $error("registers not cleared by reset");

    property p_mute;
        s_gain_write_mute ##1 !wr_gain |-> ##1 sine_mute;
    endproperty
    a_mute: assert property (p_mute) else $error("mute code did not mute");

    property p_mute_edge;
        (sine_gain_reg == 8'hef) |=> !sine_mute;
    endproperty
    a_mute_edge: assert property (p_mute_edge) else $error("code ef muted");

    property p_band;
        logic b;
        (s_route_write, b = wr_data[7]) ##1 !wr_route |-> ##1 (sine_band_select == b);
    endproperty
    a_band: assert property (p_band) else $error("range bit not applied");

    property p_coarse;
        logic [3:0] m;
        (s_route_write, m = wr_data[3:0]) ##1 !wr_route |-> ##1 (coarse_factor == m);
    endproperty
    a_coarse: assert property (p_coarse) else $error("coarse factor not applied");

    property p_total;
        ##1 1'h1 |-> sine_total_atten ==
            10'(({7'h00, $past(analog_range)} * 10'h00c) + {2'h0, $past(sine_gain_reg)});
    endproperty
    a_total: assert property (p_total) else $error("total attenuation wrong");

    property p_gate_closed;
        (!gate_sync && !digital_mode) |=>
            !route_in_pos_to_out_pos && !route_in_neg_to_out_neg && !route_in_pos_to_out_neg
            && !route_in_neg_to_out_pos && !route_out_short;
    endproperty
    a_gate_closed: assert property (p_gate_closed) else $error("switch not forced open");

    property p_digital_follow;
        digital_mode |=> (route_active == $past(route_config));
    endproperty
    a_digital_follow: assert property (p_digital_follow) else $error("digital mode not following");

    property p_gate_follow;
        gate_sync |=> (route_active == $past(route_config));
    endproperty
    a_gate_follow: assert property (p_gate_follow) else $error("gated route not applied");

    property p_diff;
        (route_active == 3'h1) |-> route_in_pos_to_out_pos && route_in_neg_to_out_neg
            && !route_in_pos_to_out_neg && !route_in_neg_to_out_pos && !route_out_short;
    endproperty
    a_diff: assert property (p_diff) else $error("straight routing wrong");

    property p_cross;
        (route_active == 3'h2) |-> route_in_pos_to_out_neg && route_in_neg_to_out_pos
            && !route_in_pos_to_out_pos && !route_in_neg_to_out_neg;
    endproperty
    a_cross: assert property (p_cross) else $error("crossed routing wrong");

    property p_cm_pos;
        (route_active == 3'h3) |-> route_in_pos_to_out_pos && route_in_pos_to_out_neg
            && !route_in_neg_to_out_neg && !route_in_neg_to_out_pos;
    endproperty
    a_cm_pos: assert property (p_cm_pos) else $error("common positive wrong");

    property p_short;
        (route_active == 3'h7) |-> route_out_short && !route_in_pos_to_out_pos
            && !route_in_neg_to_out_neg;
    endproperty
    a_short: assert property (p_short) else $error("short routing wrong");

    property p_route_timing;
        (s_route_write ##1 !wr_route) and (digital_mode [*3]) |->
            (route_active == $past(wr_data[6:4], 2));
    endproperty
    a_route_timing: assert property (p_route_timing) else $error("route write late");

    property p_read_gain;
        rd_en && sel_gain && !$past(wr_gain) |=> (rd_data == $past(sine_gain_reg));
    endproperty
    a_read_gain: assert property (p_read_gain) else $error("gain readback wrong");

    property p_read_idle;
        !rd_en |=> (rd_data == 8'h00);
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside read slot");

endmodule

`default_nettype wire

// file: logic/sgs_route_switch.sv
// Signal switch decoder: routing code and gate to registered switch enables
`default_nettype none

module sgs_route_switch (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Control
    input wire logic [2:0] route_config,
    input wire logic gate_sync,
    input wire logic digital_mode,
    // Switch enables
    output logic pos_to_pos,
    output logic neg_to_neg,
    output logic pos_to_neg,
    output logic neg_to_pos,
    output logic out_short,
    output logic [2:0] route_active
);

    // ------------------------------------------------------------
    // Effective code
    // ------------------------------------------------------------
    wire logic route_enable;
    wire logic [2:0] eff_code;
    wire logic [4:0] next_switch;

    assign route_enable = digital_mode | gate_sync;
    assign eff_code = route_enable ? route_config : sgs_pkg::SGS_ROUTE_OPEN;

    // Order: pp, nn, pn, np, short
    assign next_switch = (eff_code == sgs_pkg::SGS_ROUTE_DIFF) ? 5'h03 :
                     (eff_code == sgs_pkg::SGS_ROUTE_DIFF_REV) ? 5'h0c :
                     (eff_code == sgs_pkg::SGS_ROUTE_CM_POS)   ? 5'h05 :
                     (eff_code == sgs_pkg::SGS_ROUTE_CM_NEG)   ? 5'h0a :
                     (eff_code == sgs_pkg::SGS_ROUTE_SE_POS)   ? 5'h01 :
                     (eff_code == sgs_pkg::SGS_ROUTE_SE_NEG)   ? 5'h02 :
                     (eff_code == sgs_pkg::SGS_ROUTE_SHORT)    ? 5'h10 :
                     5'h00;

    // ------------------------------------------------------------
    // Output flops
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            {out_short, neg_to_pos, pos_to_neg, neg_to_neg, pos_to_pos} <= 5'h00;
            route_active <= sgs_pkg::SGS_ROUTE_OPEN;
        end else begin
            {out_short, neg_to_pos, pos_to_neg, neg_to_neg, pos_to_pos} <= next_switch;
            route_active <= eff_code;
        end
    end

endmodule

`default_nettype wire

// file: test/sgs_regs_bench.sv
// Self-checking bench for the sine gain and switch register block
`default_nettype none

module sgs_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic ref_clk = 1'h0;
    logic nrst = 1'h0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'h0;
    logic rd_en = 1'h0;
    logic [1:0] op_mode = 2'h0;
    logic [2:0] analog_range = 3'h0;
    logic route_gate_pin = 1'h0;
    logic [7:0] rd_data;
    logic [7:0] digital_atten_value;
    logic sine_mute;
    logic [9:0] sine_total_atten;
    logic sine_band_select;
    logic [3:0] coarse_factor;
    logic pp, nn, pn, np, sh;
    logic [4:0] route_seen;
    logic [7:0] rr;
    int error_cnt = 0;
    int check_count = 0;

    // Switch pattern per code as {pp, nn, pn, np, short}
    logic [4:0] route_tbl [8] = '{5'h00, 5'h18, 5'h06, 5'h14, 5'h0a, 5'h10, 5'h08, 5'h01};
    // Boundary gain codes: zero, one step, mid, last audible, mute edges
    logic [7:0] gain_tbl [6] = '{8'h00, 8'h01, 8'h7f, 8'hef, 8'hf0, 8'hff};
    logic [2:0] rng_tbl [6] = '{3'h0, 3'h6, 3'h1, 3'h4, 3'h0, 3'h7};

    assign route_seen = {pp, nn, pn, np, sh};

    sgs_regs sgs_regs_i (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .addr(addr),
        .wr_data(wr_data),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .op_mode(op_mode),
        .analog_range(analog_range),
        .route_gate_pin(route_gate_pin),
        .digital_atten_value(digital_atten_value),
        .sine_mute(sine_mute),
        .sine_total_atten(sine_total_atten),
        .sine_band_select(sine_band_select),
        .coarse_factor(coarse_factor),
        .route_in_pos_to_out_pos(pp),
        .route_in_neg_to_out_neg(nn),
        .route_in_pos_to_out_neg(pn),
        .route_in_neg_to_out_pos(np),
        .route_out_short(sh)
    );

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------
    // Compare, bus and wait tasks
    // ------------------------------------------------------------
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk10(input string what, input logic [9:0] exp, input logic [9:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_en <= 1'h1;
        addr <= a;
        wr_data <= d;
        @(posedge ref_clk);
        wr_en <= 1'h0;
    endtask

    // Read data only stands in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        rd_en <= 1'h1;
        addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'h0;
        #1;
        chk8("rd_data", exp, rd_data);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk_route(input logic [2:0] code);
        chk8("switches", {3'h0, route_tbl[code]}, {3'h0, route_seen});
    endtask

    task automatic chk_rate(input logic [7:0] v);
        chk8("band_coarse", {3'h0, v[7], v[3:0]}, {3'h0, sine_band_select, coarse_factor});
    endtask

    task automatic chk_gain(input logic [7:0] code);
        chk8("atten", code, digital_atten_value);
        chk8("mute", {7'h0, code >= 8'hf0}, {7'h0, sine_mute});
        chk10("total", {7'h0, analog_range} * 10'h00c + {2'h0, code}, sine_total_atten);
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk);
        nrst <= 1'h1;
        wait_cyc(1);
        chk_gain(8'h00);
        chk_route(3'h0);
        chk_rate(8'h00);
        rd(sgs_pkg::SINE_GAIN_OFS, 8'h00);
        rd(sgs_pkg::ROUTE_RATE_OFS, 8'h00);
        $display("test reset values done");

        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            analog_range <= rng_tbl[i];
            wr(sgs_pkg::SINE_GAIN_OFS, gain_tbl[i]);
            wait_cyc(1);
            chk_gain(gain_tbl[i]);
            rd(sgs_pkg::SINE_GAIN_OFS, gain_tbl[i]);
        end
        $display("test sine gain done");

        // Gate high in sine mode: every code routes
        @(posedge ref_clk);
        route_gate_pin <= 1'h1;
        wait_cyc(3);
        for (int c = 0; c < 8; c++) begin
            rr = {c[0], 3'(c), 4'(15 - c)};
            wr(sgs_pkg::ROUTE_RATE_OFS, rr);
            wait_cyc(1);
            chk_route(3'(c));
            chk_rate(rr);
            rd(sgs_pkg::ROUTE_RATE_OFS, rr);
        end
        $display("test routing with gate high done");

        // Gate low forces open, digital mode overrides the gate
        wr(sgs_pkg::ROUTE_RATE_OFS, 8'h10);
        @(posedge ref_clk);
        route_gate_pin <= 1'h0;
        wait_cyc(2);
        chk_route(3'h1);
        wait_cyc(1);
        chk_route(3'h0);
        @(posedge ref_clk);
        op_mode <= sgs_pkg::MODE_DIGITAL;
        wait_cyc(1);
        chk_route(3'h1);
        for (int c = 2; c < 8; c++) begin
            wr(sgs_pkg::ROUTE_RATE_OFS, {1'h0, 3'(c), 4'h0});
            wait_cyc(1);
            chk_route(3'(c));
        end
        @(posedge ref_clk);
        op_mode <= 2'h1;
        wait_cyc(1);
        chk_route(3'h0);
        @(posedge ref_clk);
        op_mode <= 2'h3;
        wait_cyc(1);
        chk_route(3'h0);
        @(posedge ref_clk);
        op_mode <= 2'h0;
        route_gate_pin <= 1'h1;
        wait_cyc(2);
        chk_route(3'h0);
        wait_cyc(1);
        chk_route(3'h7);
        $display("test gate and digital mode done");

        // Unmapped and read-only places leave registers untouched
        wr(8'h00, 8'hff);
        wr(8'hff, 8'hff);
        wr(sgs_pkg::STATUS_OFS, 8'hff);
        rd(8'h00, 8'h00);
        rd(8'hff, 8'h00);
        rd(sgs_pkg::SINE_GAIN_OFS, 8'hff);
        rd(sgs_pkg::ROUTE_RATE_OFS, 8'h70);
        rd(sgs_pkg::STATUS_OFS, 8'hc7);
        // Write then read with no gap returns the new value
        @(posedge ref_clk);
        wr_en <= 1'h1;
        addr <= sgs_pkg::SINE_GAIN_OFS;
        wr_data <= 8'h3c;
        @(posedge ref_clk);
        wr_en <= 1'h0;
        rd_en <= 1'h1;
        @(posedge ref_clk);
        rd_en <= 1'h0;
        #1;
        chk8("rd_data", 8'h3c, rd_data);
        wait_cyc(1);
        chk8("rd_idle", 8'h00, rd_data);
        chk_gain(8'h3c);
        $display("test bus refusals done");
        give_verdict();
    end

    // Whole run is about 140 cycles; this bound leaves wide margin
    initial begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        $display("[ERR] watchdog expected finish seen timeout");
        give_verdict();
    end

endmodule

`default_nettype wire
